// >>> design/parallel_io_port.sv
// parallel port top: registers, pin cells, stop hold
`timescale 1ns/1ps
module parallel_io_port #(
   parameter int W = gpio_port_pkg::PORT_WIDTH,
   parameter logic [W-1:0] OSC_PINS = W'(gpio_port_pkg::OSC_PIN_MASK)
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,

   // register writes
   input wire logic data_wr_in,
   input wire logic dir_wr_in,
   input wire logic pullup_wr_in,
   input wire logic slew_wr_in,
   input wire logic drive_wr_in,
   input wire logic [W-1:0] wr_data_in,

   // register read
   output logic [W-1:0] rd_data_out,

   // partial power-down control and status
   input wire logic stop2_enter_in,
   input wire logic stop2_wake_in,
   input wire logic powerdown_ack_in,
   output logic partial_powerdown_flag_out,

   // shared functions
   input wire logic [W-1:0] alt_en_in,
   input wire logic [W-1:0] alt_oe_in,
   input wire logic [W-1:0] alt_out_in,
   input wire logic [W-1:0] analog_en_in,
   input wire logic [W-1:0] kbi_en_in,
   input wire logic osc_en_in,

   // pads
   input wire logic [W-1:0] pad_in,
   output logic [W-1:0] pad_oe_out,
   output logic [W-1:0] pad_out_out,
   output logic [W-1:0] pad_pullup_out,
   output logic [W-1:0] pad_slew_out,
   output logic [W-1:0] pad_drive_out
);

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   logic [W-1:0] port_data_latch;
   logic [W-1:0] port_direction_bits;
   logic [W-1:0] pullup_enable_bits;
   logic [W-1:0] slew_limit_enable_bits;
   logic [W-1:0] high_drive_select_bits;

   port_ctrl_reg #(.W(W)) u_data (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(data_wr_in),
      .wr_data_in(wr_data_in),
      .q_out(port_data_latch)
   );

   port_ctrl_reg #(.W(W)) u_dir (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(dir_wr_in),
      .wr_data_in(wr_data_in),
      .q_out(port_direction_bits)
   );

   port_ctrl_reg #(.W(W)) u_pullup (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(pullup_wr_in),
      .wr_data_in(wr_data_in),
      .q_out(pullup_enable_bits)
   );

   port_ctrl_reg #(.W(W)) u_slew (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(slew_wr_in),
      .wr_data_in(wr_data_in),
      .q_out(slew_limit_enable_bits)
   );

   port_ctrl_reg #(.W(W)) u_drive (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .wr_en_in(drive_wr_in),
      .wr_data_in(wr_data_in),
      .q_out(high_drive_select_bits)
   );

   ////////////////////////////////////////////////////////////////////////////
   // per-pin priority cells

   logic [W-1:0] osc_w;
   logic [W-1:0] oe_w;
   logic [W-1:0] out_w;
   logic [W-1:0] pullup_w;
   logic [W-1:0] slew_w;
   logic [W-1:0] drive_w;
   logic [W-1:0] rd_w;

   assign osc_w = osc_en_in ? OSC_PINS : '0;

   for (genvar i = 0; i < W; i++) begin : g_pin
      port_pin_cell u_cell (
         .data_in(port_data_latch[i]),
         .dir_in(port_direction_bits[i]),
         .pullup_en_in(pullup_enable_bits[i]),
         .slew_en_in(slew_limit_enable_bits[i]),
         .drive_sel_in(high_drive_select_bits[i]),
         .alt_en_in(alt_en_in[i]),
         .alt_oe_in(alt_oe_in[i]),
         .alt_out_in(alt_out_in[i]),
         .analog_en_in(analog_en_in[i]),
         .kbi_en_in(kbi_en_in[i]),
         .osc_en_in(osc_w[i]),
         .pin_in(pad_in[i]),
         .oe_out(oe_w[i]),
         .out_out(out_w[i]),
         .pullup_out(pullup_w[i]),
         .slew_out(slew_w[i]),
         .drive_out(drive_w[i]),
         .rd_out(rd_w[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // partial power-down hold

   gpio_port_pkg::hold_state_t state_q;
   gpio_port_pkg::hold_state_t state_d;
   logic held_w;
   logic hold_now_w;
   logic flag_q;
   logic flag_d;

   assign held_w = (state_q == gpio_port_pkg::HS_HELD);
   assign hold_now_w = held_w | stop2_enter_in;

   always_comb begin
      state_d = state_q;
      case (state_q)
         gpio_port_pkg::HS_RUN: begin
            if (stop2_enter_in) begin
               state_d = gpio_port_pkg::HS_HELD;
            end
         end
         gpio_port_pkg::HS_HELD: begin
            if (powerdown_ack_in) begin
               state_d = gpio_port_pkg::HS_RUN;
            end
         end
         default: begin
            state_d = gpio_port_pkg::HS_RUN;
         end
      endcase
   end

   // wake while held sets the flag, acknowledge clears it, set wins
   assign flag_d = (stop2_wake_in & held_w) | (flag_q & ~powerdown_ack_in);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= gpio_port_pkg::HOLD_RESET;
         flag_q <= gpio_port_pkg::REG_RESET_BIT;
      end else begin
         state_q <= state_d;
         flag_q <= flag_d;
      end
   end

   assign partial_powerdown_flag_out = flag_q;

   ////////////////////////////////////////////////////////////////////////////
   // registered pad controls and read data

   logic [W-1:0] oe_q;
   logic [W-1:0] out_q;
   logic [W-1:0] pullup_q;
   logic [W-1:0] slew_q;
   logic [W-1:0] drive_q;
   logic [W-1:0] rd_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         oe_q <= '0;
         out_q <= '0;
         pullup_q <= '0;
         slew_q <= '0;
         drive_q <= '0;
      end else if (!hold_now_w) begin
         oe_q <= oe_w;
         out_q <= out_w;
         pullup_q <= pullup_w;
         slew_q <= slew_w;
         drive_q <= drive_w;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_w;
      end
   end

   assign pad_oe_out = oe_q;
   assign pad_out_out = out_q;
   assign pad_pullup_out = pullup_q;
   assign pad_slew_out = slew_q;
   assign pad_drive_out = drive_q;
   assign rd_data_out = rd_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   logic [W-1:0] in_sel_w;
   logic [W-1:0] latch_sel_w;
   logic [W-1:0] alt_drv_w;
   logic [W-1:0] port_drv_w;
   logic [W-1:0] ctrl_or_w;

   assign in_sel_w = ~port_direction_bits & ~analog_en_in;
   assign latch_sel_w = port_direction_bits & ~analog_en_in;
   assign alt_drv_w = alt_en_in & alt_oe_in & ~analog_en_in & ~kbi_en_in & ~osc_w;
   assign port_drv_w = port_direction_bits & ~alt_en_in & ~analog_en_in & ~kbi_en_in
                     & ~osc_w;
   assign ctrl_or_w = pad_oe_out | pad_pullup_out | pad_slew_out | pad_drive_out;

   sequence s_enter;
      stop2_enter_in && !held_w;
   endsequence

   sequence s_held_ack;
      held_w && powerdown_ack_in;
   endsequence

   a_input_read:
   assert property (!rst_in |=> ((rd_data_out ^ $past(pad_in)) & $past(in_sel_w)) == '0)
      else $error("input pin read not pin level");

   a_output_read:
   assert property (!rst_in |=> ((rd_data_out ^ $past(port_data_latch))
                    & $past(latch_sel_w)) == '0)
      else $error("output pin read not latch value");

   a_port_drive:
   assert property (!rst_in && !hold_now_w
                    |=> ((~pad_oe_out | (pad_out_out ^ $past(port_data_latch)))
                    & $past(port_drv_w)) == '0)
      else $error("port output not driving latch");

   a_alt_dir:
   assert property (!rst_in && !hold_now_w |=> ((pad_oe_out ^ $past(alt_oe_in))
                    & $past(alt_en_in & ~analog_en_in & ~kbi_en_in & ~osc_w)) == '0)
      else $error("shared function direction ignored");

   a_alt_level:
   assert property (!rst_in && !hold_now_w |=> ((pad_out_out ^ $past(alt_out_in))
                    & $past(alt_drv_w)) == '0)
      else $error("shared output level not used");

   a_analog_zero:
   assert property (1'b1 |=> (rd_data_out & $past(analog_en_in)) == '0)
      else $error("analog pin read not zero");

   a_analog_wins:
   assert property (!hold_now_w |=> (ctrl_or_w & $past(analog_en_in)) == '0)
      else $error("analog pin still digital");

   a_kbi_input:
   assert property (!hold_now_w |=> (pad_oe_out & $past(kbi_en_in)) == '0)
      else $error("keyboard pin driven");

   a_osc_free:
   assert property (!hold_now_w && osc_en_in |=> (ctrl_or_w & OSC_PINS) == '0)
      else $error("oscillator pin under port control");

   a_pullup_off:
   assert property ((pad_pullup_out & pad_oe_out) == '0)
      else $error("pullup on while driving");

   a_slew_input:
   assert property (((pad_slew_out | pad_drive_out) & ~pad_oe_out) == '0)
      else $error("slew or drive on an input");

   a_hold_keep:
   assert property (s_enter |=> $stable(pad_oe_out) && $stable(pad_out_out) && held_w)
      else $error("pins not held on entry");

   a_wake_flag:
   assert property (held_w && stop2_wake_in |=> partial_powerdown_flag_out)
      else $error("wake did not set flag");

   a_ack_release:
   assert property (s_held_ack |=> !held_w ##1 (pad_oe_out == $past(oe_w)
                    || $past(stop2_enter_in)))
      else $error("acknowledge did not release pins");

   a_reset_clear:
   assert property ($fell(rst_in) |-> pad_oe_out == '0 && pad_pullup_out == '0
                    && !partial_powerdown_flag_out)
      else $error("reset left pins active");

   a_pullup_on:
   assert property (!rst_in && !hold_now_w |=> (pad_pullup_out ^ $past(pullup_enable_bits
                    & ~oe_w & ~analog_en_in & ~osc_w)) == '0)
      else $error("pullup not following enable");

   a_slew_out:
   assert property (!rst_in && !hold_now_w |=> (pad_slew_out ^ $past(slew_limit_enable_bits
                    & oe_w)) == '0)
      else $error("slew limit not on driven pin");

   a_drive_sel:
   assert property (!rst_in && !hold_now_w |=> (pad_drive_out ^ $past(high_drive_select_bits
                    & oe_w)) == '0)
      else $error("high drive not on driven pin");

   a_ctrl_keep:
   assert property (!rst_in && !pullup_wr_in && !slew_wr_in && !drive_wr_in
                    |=> $stable(pullup_enable_bits) && $stable(slew_limit_enable_bits)
                    && $stable(high_drive_select_bits))
      else $error("pin control changed without write");

   a_data_keep:
   assert property (!rst_in && !data_wr_in && !dir_wr_in
                    |=> $stable(port_data_latch) && $stable(port_direction_bits))
      else $error("port state changed without write");

   a_held_frozen:
   assert property (held_w |=> $stable(pad_oe_out) && $stable(pad_out_out)
                    && $stable(pad_pullup_out) && $stable(pad_slew_out))
      else $error("held pins changed");

   a_wake_ignored:
   assert property (!held_w && !partial_powerdown_flag_out |=> !partial_powerdown_flag_out)
      else $error("flag set without held wake");

   a_ack_flag:
   assert property (powerdown_ack_in && !stop2_wake_in |=> !partial_powerdown_flag_out)
      else $error("acknowledge did not clear flag");

endmodule : parallel_io_port

// >>> design/gpio_port_pkg.sv
// constants and types shared by the parallel port with pin control
// Operation
// - direction 0: driver off, read pin
// - direction 1: driver on, read latch
// - direction bit picks read source under override
// - shared timer function decides pin direction
// - shared function output drives pin level
// - analog disables digital, reads return zero
// - analog wins over alternate digital function
// - keyboard input forces pin input
// - oscillator pins ignore port registers
// - pullup only on non-driven digital pins
// - slew limit only on output pins
// - high drive only on output pins
// - pin control independent of data, direction
// - partial power-down holds pin state
// - acknowledge write releases held pins
// - light stop keeps all state intact
// - data writes latch all bits
// - reset clears registers, pins input
package gpio_port_pkg;

   // default number of pins of one port
   localparam int PORT_WIDTH = 8;

   // value of every register bit after reset
   localparam logic REG_RESET_BIT = 1'b0;

   // oscillator pin positions on port g
   localparam int OSC_IN_BIT = 5;
   localparam int OSC_OUT_BIT = 6;
   localparam logic [7:0] OSC_PIN_MASK = 8'h60;

   // level read back for an analog pin
   localparam logic ANALOG_READ_BIT = 1'b0;

   // pin hold state across partial power-down
   typedef enum logic [1:0] {
      HS_RUN = 2'b01,
      HS_HELD = 2'b10
   } hold_state_t;

   localparam hold_state_t HOLD_RESET = HS_RUN;

endpackage : gpio_port_pkg

// >>> design/port_ctrl_reg.sv
// one software-written control register of the port
`timescale 1ns/1ps
module port_ctrl_reg #(
   parameter int W = gpio_port_pkg::PORT_WIDTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // write side
   input wire logic wr_en_in,
   input wire logic [W-1:0] wr_data_in,
   // stored value
   output logic [W-1:0] q_out
);

   logic [W-1:0] val_q;
   logic [W-1:0] val_d;

   assign val_d = wr_en_in ? wr_data_in : val_q;
   assign q_out = val_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         val_q <= {W{gpio_port_pkg::REG_RESET_BIT}};
      end else begin
         val_q <= val_d;
      end
   end

endmodule : port_ctrl_reg

// >>> design/port_pin_cell.sv
// per-pin override priority and read-back selection
`timescale 1ns/1ps
module port_pin_cell (
   // port registers for this pin
   input wire logic data_in,
   input wire logic dir_in,
   input wire logic pullup_en_in,
   input wire logic slew_en_in,
   input wire logic drive_sel_in,
   // shared functions for this pin
   input wire logic alt_en_in,
   input wire logic alt_oe_in,
   input wire logic alt_out_in,
   input wire logic analog_en_in,
   input wire logic kbi_en_in,
   input wire logic osc_en_in,
   // pad level
   input wire logic pin_in,
   // pad controls and read value
   output logic oe_out,
   output logic out_out,
   output logic pullup_out,
   output logic slew_out,
   output logic drive_out,
   output logic rd_out
);

   logic digital_w;
   logic alt_w;
   logic dir_w;

   // analog first, then oscillator, keyboard, timer, port
   assign digital_w = ~analog_en_in & ~osc_en_in;
   assign alt_w = alt_en_in & digital_w;
   assign dir_w = alt_w ? alt_oe_in : dir_in;
   assign oe_out = digital_w & ~kbi_en_in & dir_w;
   assign out_out = (alt_w & alt_oe_in) ? alt_out_in : data_in;
   assign pullup_out = pullup_en_in & digital_w & ~oe_out;
   assign slew_out = slew_en_in & oe_out;
   assign drive_out = drive_sel_in & oe_out;
   assign rd_out = analog_en_in ? gpio_port_pkg::ANALOG_READ_BIT
                 : (dir_in ? data_in : pin_in);

endmodule : port_pin_cell

// >>> dv/pad_far_side.sv
// model of the external circuitry on the port pins
`timescale 1ns/1ps
module pad_far_side #(
   parameter int W = 8
) (
   // clock
   input wire logic clk_in,
   // pad controls from the port
   input wire logic [W-1:0] pad_oe_in,
   input wire logic [W-1:0] pad_out_in,
   input wire logic [W-1:0] pad_pullup_in,
   // external drivers
   input wire logic [W-1:0] ext_en_in,
   input wire logic [W-1:0] ext_val_in,
   // resolved pin level
   output logic [W-1:0] pad_level_out
);
   ////////////////////////////////////////
   // an undriven pin without pullup toggles every cycle
   logic [W-1:0] float_q = '0;
   always @(posedge clk_in) begin
      float_q <= ~float_q;
   end
   // port driver wins, then external driver, then pullup
   for (genvar i = 0; i < W; i++) begin : g_pin
      assign pad_level_out[i] = pad_oe_in[i] ? pad_out_in[i] :
         ext_en_in[i] ? ext_val_in[i] : (pad_pullup_in[i] | float_q[i]);
   end
endmodule : pad_far_side

// >>> dv/parallel_io_port_bench.sv
// self-checking bench for the parallel port with pin control
`timescale 1ns/1ps
module parallel_io_port_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [4:0] wr_sel = 5'h00;
   logic [2:0] pd = 3'h0;
   logic osc = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] alt_en = 8'h00;
   logic [7:0] alt_oe = 8'h00;
   logic [7:0] alt_out = 8'h00;
   logic [7:0] ana = 8'h00;
   logic [7:0] keyboard_interrupt_input = 8'h00;
   logic [7:0] ext_en = 8'hff;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] pad, oe, po, pu, sl, dr, rd;
   logic flag;
   int miscompares = 0;
   int checks_done = 0;
   always #5 clk_in = ~clk_in;
   ////////////////////////////////////////
   parallel_io_port dut (.clk_in(clk_in), .rst_in(rst_in),
      .data_wr_in(wr_sel[4]), .dir_wr_in(wr_sel[3]), .pullup_wr_in(wr_sel[2]),
      .slew_wr_in(wr_sel[1]), .drive_wr_in(wr_sel[0]), .wr_data_in(wr_data),
      .rd_data_out(rd), .stop2_enter_in(pd[2]), .stop2_wake_in(pd[1]),
      .powerdown_ack_in(pd[0]), .partial_powerdown_flag_out(flag),
      .alt_en_in(alt_en), .alt_oe_in(alt_oe), .alt_out_in(alt_out),
      .analog_en_in(ana), .kbi_en_in(keyboard_interrupt_input), .osc_en_in(osc), .pad_in(pad),
      .pad_oe_out(oe), .pad_out_out(po), .pad_pullup_out(pu),
      .pad_slew_out(sl), .pad_drive_out(dr));
   pad_far_side far (.clk_in(clk_in), .pad_oe_in(oe), .pad_out_in(po),
      .pad_pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val),
      .pad_level_out(pad));
   ////////////////////////////////////////
   task automatic end_sim;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   task automatic wr(input logic [4:0] sel, input logic [7:0] d);
      @(posedge clk_in);
      wr_sel <= sel;
      wr_data <= d;
      @(posedge clk_in);
      wr_sel <= 5'h00;
   endtask : wr
   task automatic pulse(input logic [2:0] p);
      @(posedge clk_in);
      pd <= p;
      @(posedge clk_in);
      pd <= 3'h0;
   endtask : pulse
   // waits for pads and read-back to settle, then checks pad controls and read data, not the flag
   task automatic pads(input logic [7:0] e_oe, e_out, e_pu, e_sl, e_dr, e_rd);
      tick(3);
      #1;
      cmp(oe, e_oe);
      cmp(po & oe, e_out);
      cmp(pu, e_pu);
      cmp(sl, e_sl);
      cmp(dr, e_dr);
      cmp(rd, e_rd);
   endtask : pads
   ////////////////////////////////////////
   task automatic s_reset;
      pads(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
   endtask : s_reset
   task automatic s_dir;
      wr(5'h10, 8'ha5);
      wr(5'h08, 8'h0f);
      ext_val <= 8'h3c;
      pads(8'h0f, 8'h05, 8'h00, 8'h00, 8'h00, 8'h35);
   endtask : s_dir
   task automatic s_alt;
      @(posedge clk_in);
      alt_en <= 8'h31;
      alt_oe <= 8'h10;
      alt_out <= 8'h10;
      pads(8'h1e, 8'h14, 8'h00, 8'h00, 8'h00, 8'h35);
      @(posedge clk_in);
      alt_en <= 8'h00;
      alt_out <= 8'h00;
   endtask : s_alt
   task automatic s_pinctl;
      wr(5'h07, 8'hff);
      ext_en <= 8'h7f;
      pads(8'h0f, 8'h05, 8'hf0, 8'h0f, 8'h0f, 8'hb5);
   endtask : s_pinctl
   task automatic s_analog;
      @(posedge clk_in);
      ana <= 8'h81;
      alt_en <= 8'h01;
      alt_oe <= 8'h01;
      pads(8'h0e, 8'h04, 8'h70, 8'h0e, 8'h0e, 8'h34);
      @(posedge clk_in);
      ana <= 8'h00;
      alt_en <= 8'h00;
   endtask : s_analog
   task automatic s_kbi;
      @(posedge clk_in);
      keyboard_interrupt_input <= 8'h06;
      pads(8'h09, 8'h01, 8'hf6, 8'h09, 8'h09, 8'hb5);
      @(posedge clk_in);
      keyboard_interrupt_input <= 8'h00;
   endtask : s_kbi
   task automatic s_osc;
      @(posedge clk_in);
      osc <= 1'b1;
      wr(5'h08, 8'h6f);
      pads(8'h0f, 8'h05, 8'h90, 8'h0f, 8'h0f, 8'hb5);
      @(posedge clk_in);
      osc <= 1'b0;
      wr(5'h08, 8'h0f);
   endtask : s_osc
   task automatic s_stop;
      pulse(3'h4);
      wr(5'h10, 8'h5a);
      pads(8'h0f, 8'h05, 8'hf0, 8'h0f, 8'h0f, 8'hba);
      cmp({7'h00, flag}, 8'h00);
      pulse(3'h2);
      tick(1);
      #1;
      cmp({7'h00, flag}, 8'h01);
      pulse(3'h1);
      pads(8'h0f, 8'h0a, 8'hf0, 8'h0f, 8'h0f, 8'hba);
      cmp({7'h00, flag}, 8'h00);
      pulse(3'h2);
      tick(1);
      #1;
      cmp({7'h00, flag}, 8'h00);
   endtask : s_stop
   // reset in mid-run while held: registers cleared and hold released
   task automatic s_rerun;
      pulse(3'h4);
      rst_in <= 1'b1;
      ext_en <= 8'hff;
      tick(5);
      rst_in <= 1'b0;
      pads(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c);
      wr(5'h08, 8'h0f);
      pads(8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30);
   endtask : s_rerun
   ////////////////////////////////////////
   initial begin
      tick(5);
      rst_in <= 1'b0;
      s_reset();
      s_dir();
      s_alt();
      s_pinctl();
      s_analog();
      s_kbi();
      s_osc();
      s_stop();
      s_rerun();
      end_sim();
   end
   initial begin
      tick(3000);
      miscompares++;
      end_sim();
   end
endmodule : parallel_io_port_bench
